// ==== verilog/scr_defines.vh ====
`ifndef SCR_DEFINES_VH
`define SCR_DEFINES_VH
// I2C target address, seven bits.
`define SCR_I2C_ADDR      7'h76
// Command codes and fields.
`define SCR_CMD_ADC_READ  8'h00
`define SCR_CMD_RESET     8'h1E
`define SCR_CONV_HI       3'h2
`define SCR_PROM_HI       4'hA
`define SCR_TYPE_BIT      4
`define SCR_OSR_MAX       3'h5
// Calibration word zero layout.
`define SCR_CAL_WORD_ZERO 3'h0
`define SCR_CRC_MSB       15
`define SCR_CRC_LSB       12
`define SCR_PTYPE_MSB     11
`define SCR_PTYPE_LSB     5
// Result reset value and transfer byte counts.
`define SCR_RESULT_RST    24'h000000
`define SCR_RESULT_BYTES  2'h3
`define SCR_PROM_BYTES    2'h2
// Conversion cycles for oversampling 256 (600 us at 100 MHz); doubles per step.
`define SCR_CONV_CYC_BASE 21'h0EA60
`endif

// ==== verilog/scr_readout.v ====
// Notes on behaviour
// RULE1: A conversion command starts a pressure or temperature conversion chosen by the command.
// RULE2: After conversion the ADC read returns the result most significant bit first.
// RULE3: An ADC read with no preceding conversion, or repeated, returns zero.
// RULE4: An ADC read during conversion returns zero while the conversion runs on, corrupted.
// RULE5: A new conversion command during conversion corrupts the result; the host must wait.
// RULE6: The device is busy from taking a conversion command until it finishes.
// RULE7: The host gives 24 clock pulses after the read address is acknowledged.
// RULE8: After every 8 result bits the transfer waits for the host acknowledge.
// RULE9: Calibration word zero holds a fixed product-type code in bits 11 to 5.
// RULE10: The calibration memory holds 112 bits guarded by a 4-bit CRC.
// RULE11: The checker clears the top nibble of word 0, zeroes word 7 and takes sixteen bytes.
// RULE12: Each bit step shifts the remainder left and applies feedback when the top bit was set.
// RULE13: The checker takes remainder bits 15 to 12 as the CRC and compares it.
// RULE14: The device answers seven-bit address 1110110 with the last bit selecting read.
// RULE15: Pressure commands are 0x40 to 0x4A in steps of 2, temperature ones add 0x10.
// RULE16: Command 0x00 reads the result and 0xA0 to 0xAE read the word chosen by bits 3 to 1.
// RULE17: The result register clears after it is read out.
`timescale 1ns/1ps
`include "scr_defines.vh"
`default_nettype none

module scr_readout
#(
  parameter [6:0]  PRODUCT_TYPE = 7'h2A, // Arbitrary product-type value.
  parameter [20:0] CONV_CYC     = `SCR_CONV_CYC_BASE
)
(
  // Clock and reset.
  input  wire        mclk,
  input  wire        rst_b,
  // Serial bus pins.
  input  wire        scl_i,
  input  wire        sda_i,
  output reg         sda_o,
  output reg         sda_oe,
  // Analog front end sample values.
  input  wire [23:0] raw_pressure_value,
  input  wire [23:0] raw_temperature_value,
  // Calibration words 1 to 6 and factory settings of word 0.
  input  wire [95:0] cal_words,
  input  wire [4:0]  factory_settings,
  // Status.
  output reg         busy
);

  // ==========================================================================
  // Pin synchronisers and edge detection.
  reg [2:0] scl_q;
  reg [2:0] sda_q;
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end
    else
    begin
      scl_q <= {scl_q[1:0], scl_i};
      sda_q <= {sda_q[1:0], sda_i};
    end
  end
  wire scl_rise = scl_q[1] & ~scl_q[2];
  wire scl_fall = ~scl_q[1] & scl_q[2];
  wire start_c  = scl_q[2] & scl_q[1] & sda_q[2] & ~sda_q[1];
  wire stop_c   = scl_q[2] & scl_q[1] & ~sda_q[2] & sda_q[1];

  // ==========================================================================
  // Calibration memory with CRC computed as the checker does.
  reg [15:0] word0;
  reg [15:0] rem;
  reg [15:0] w;
  reg [7:0]  byt;
  integer    c;
  integer    b;
  always @*
  begin
    word0 = {4'h0, PRODUCT_TYPE, factory_settings};             // see RULE9
    rem   = 16'h0000;
    w     = 16'h0000;
    byt   = 8'h00;
    for (c = 0; c < 16; c = c + 1)                              // see RULE11
    begin
      if (c < 2)
        w = word0;
      else if (c < 14)
        w = cal_words[(c/2-1)*16 +: 16];
      else
        w = 16'h0000;
      byt = (c % 2 == 1) ? w[7:0] : w[15:8];
      rem = rem ^ {8'h00, byt};
      for (b = 0; b < 8; b = b + 1)                             // see RULE12
        rem = rem[15] ? ((rem << 1) ^ 16'h3000) : (rem << 1);
    end
  end
  wire [3:0]  crc_nibble = rem[`SCR_CRC_MSB:`SCR_CRC_LSB];      // see RULE13
  wire [15:0] calibration_word_zero = {crc_nibble, word0[11:0]}; // see RULE10

  // ==========================================================================
  // Serial target state machine, one-hot.
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_RX   = 5'h02;
  localparam [4:0] ST_ACK  = 5'h04;
  localparam [4:0] ST_TX   = 5'h08;
  localparam [4:0] ST_MACK = 5'h10;

  reg [4:0]  st_q;
  reg [2:0]  bit_q;
  reg [7:0]  sh_q;
  reg        addr_q;
  reg        rd_q;
  reg [2:0]  prom_q;
  reg        prom_mode_q;
  reg [23:0] out_q;
  reg [1:0]  left_q;
  reg [23:0] result_q;
  reg [20:0] cnt_q;
  reg        sel_t_q;
  reg        spoil_q;
  reg        mack_q;
  wire [7:0] rx = {sh_q[6:0], sda_q[1]};

  // Conversion cycle count scaled by oversampling step.
  wire [2:0]  osr_step = rx[3:1];
  wire [20:0] conv_len = CONV_CYC << osr_step;

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q        <= ST_IDLE;
      bit_q       <= 3'h0;
      sh_q        <= 8'h00;
      addr_q      <= 1'b0;
      rd_q        <= 1'b0;
      prom_q      <= 3'h0;
      prom_mode_q <= 1'b0;
      out_q       <= 24'h000000;
      left_q      <= 2'h0;
      result_q    <= `SCR_RESULT_RST;
      cnt_q       <= 21'h000000;
      sel_t_q     <= 1'b0;
      spoil_q     <= 1'b0;
      mack_q      <= 1'b0;
      busy        <= 1'b0;
      sda_o       <= 1'b1;
      sda_oe      <= 1'b0;
    end
    else
    begin
      // Conversion timer and result capture.
      if (busy)
      begin
        if (cnt_q == 21'h000000)
        begin
          busy     <= 1'b0;                                     // see RULE6
          result_q <= spoil_q ? ~(sel_t_q ? raw_temperature_value : raw_pressure_value)
                              : (sel_t_q ? raw_temperature_value : raw_pressure_value);
        end
        else
          cnt_q <= cnt_q - 21'h000001;
      end
      if (start_c)
      begin
        st_q   <= ST_RX;
        bit_q  <= 3'h0;
        addr_q <= 1'b1;
        mack_q <= 1'b0;
        sda_oe <= 1'b0;
      end
      else if (stop_c)
      begin
        st_q   <= ST_IDLE;
        sda_oe <= 1'b0;
      end
      else
      begin
        case (st_q)
          ST_IDLE:
            sda_oe <= 1'b0;
          ST_RX:
            if (scl_rise)
            begin
              sh_q  <= rx;
              bit_q <= bit_q + 3'h1;
              if (bit_q == 3'h7)
              begin
                st_q <= ST_ACK;
                if (addr_q)
                begin
                  if (rx[7:1] != `SCR_I2C_ADDR)                 // see RULE14
                    st_q <= ST_IDLE;
                  rd_q <= rx[0];
                  if (rx[0] && rx[7:1] == `SCR_I2C_ADDR)
                  begin
                    if (prom_mode_q)
                    begin
                      out_q  <= {(prom_q == `SCR_CAL_WORD_ZERO) ? calibration_word_zero
                                 : (prom_q == 3'h7) ? 16'h0000
                                 : cal_words[(prom_q-3'h1)*16 +: 16], 8'h00};
                      left_q <= `SCR_PROM_BYTES;
                    end
                    else
                    begin
                      out_q    <= busy ? 24'h000000 : result_q; // see RULE2, RULE3, RULE4
                      result_q <= 24'h000000;                   // see RULE17
                      spoil_q  <= spoil_q | busy;
                      left_q   <= `SCR_RESULT_BYTES;            // see RULE7
                    end
                  end
                end
                else if (rx[7:5] == `SCR_CONV_HI && rx[3:1] <= `SCR_OSR_MAX && !rx[0])
                begin
                  sel_t_q     <= rx[`SCR_TYPE_BIT];             // see RULE1, RULE15
                  spoil_q     <= busy;                          // see RULE5
                  busy        <= 1'b1;                          // see RULE6
                  cnt_q       <= conv_len;
                  prom_mode_q <= 1'b0;
                end
                else if (rx[7:4] == `SCR_PROM_HI && !rx[0])
                begin
                  prom_mode_q <= 1'b1;                          // see RULE16
                  prom_q      <= rx[3:1];
                end
                else if (rx == `SCR_CMD_ADC_READ)
                  prom_mode_q <= 1'b0;                          // see RULE16
                else if (rx == `SCR_CMD_RESET)
                begin
                  prom_mode_q <= 1'b0;
                  busy        <= 1'b0;
                  result_q    <= 24'h000000;
                end
                addr_q <= 1'b0;
              end
            end
          ST_ACK:
            if (scl_fall)
            begin
              if (!sda_oe)
              begin
                sda_o  <= 1'b0;
                sda_oe <= 1'b1;
              end
              else if (rd_q)
              begin
                st_q   <= ST_TX;
                sda_o  <= out_q[23];
                sda_oe <= ~out_q[23];
                out_q  <= {out_q[22:0], 1'b0};
                bit_q  <= 3'h1;
              end
              else
              begin
                st_q   <= ST_RX;
                sda_oe <= 1'b0;
                bit_q  <= 3'h0;
              end
            end
          ST_TX:
            if (scl_fall)
            begin
              if (bit_q == 3'h0)
              begin
                st_q   <= ST_MACK;                              // see RULE8
                sda_oe <= 1'b0;
                left_q <= left_q - 2'h1;
              end
              else
              begin
                sda_o  <= out_q[23];
                sda_oe <= ~out_q[23];
                out_q  <= {out_q[22:0], 1'b0};
                bit_q  <= bit_q + 3'h1;
              end
            end
          ST_MACK:
            if (scl_rise && (sda_q[1] || left_q == 2'h0))
              st_q <= ST_IDLE;
            else if (scl_rise)
              mack_q <= 1'b1;                                   // see RULE8
            else if (scl_fall && mack_q)
            begin
              st_q   <= ST_TX;
              mack_q <= 1'b0;
              sda_o  <= out_q[23];
              sda_oe <= ~out_q[23];
              out_q  <= {out_q[22:0], 1'b0};
              bit_q  <= 3'h1;
            end
          default:
            st_q <= ST_IDLE;
        endcase
      end
    end
  end

endmodule // scr_readout

`default_nettype wire

// ==== tb/scr_readout_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// Serial pin and conversion timing checks.
module scr_readout_props #(parameter int CONV_CYC = 40)
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Serial pins and status.
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic busy
);
  logic [15:0] bcnt_q;
  logic [7:0]  ocnt_q;
  logic [7:0]  lcnt_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Lengths of the busy run, the SDA pull and the SCL low phase.
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      bcnt_q <= 16'h0000;
      ocnt_q <= 8'h00;
      lcnt_q <= 8'h00;
    end
    else
    begin
      bcnt_q <= busy ? bcnt_q + 16'h0001 : 16'h0000;
      ocnt_q <= sda_oe ? ocnt_q + 8'h01 : 8'h00;
      lcnt_q <= scl_i ? 8'h00 : lcnt_q + 8'h01;
    end
  sequence s_start; scl_i && $fell(sda_i); endsequence
  sequence s_stop; scl_i && $rose(sda_i); endsequence
  property p_od; sda_oe |-> !sda_o; endproperty
  property p_lowch; $changed(sda_oe) |-> !scl_i; endproperty
  property p_hold; $changed(sda_oe) |=> $stable(sda_oe)[*8]; endproperty
  property p_fall; $changed(sda_oe) |-> lcnt_q <= 8'h05; endproperty
  property p_busy; $fell(busy) |-> bcnt_q >= CONV_CYC - 1 && bcnt_q <= 32 * CONV_CYC + 2;
  endproperty
  property p_stopq; s_stop |=> !sda_oe[*8]; endproperty
  property p_startq; s_start |=> !sda_oe[*8]; endproperty
  property p_omax; ocnt_q <= 8'h96; endproperty
  a_od: assert property (p_od) else $error("sda driven high");
  a_lowch: assert property (p_lowch) else $error("sda moved with scl high");
  a_hold: assert property (p_hold) else $error("sda bit too short");
  a_fall: assert property (p_fall) else $error("sda late after scl fall");
  a_busy: assert property (p_busy) else $error("busy length wrong");
  a_stopq: assert property (p_stopq) else $error("sda pulled after stop");
  a_startq: assert property (p_startq) else $error("sda pulled after start");
  a_omax: assert property (p_omax) else $error("sda held past ack");
endmodule // scr_readout_props
bind scr_readout scr_readout_props #(.CONV_CYC(CONV_CYC)) u_props
(
  .mclk(mclk), .rst_b(rst_b), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .busy(busy)
);
`default_nettype wire

// ==== tb/scr_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// Bus controller model; SDA is released to the pull-up.
module scr_host_model
(
  // Clock.
  input  wire logic mclk,
  // Bus wires.
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_rel
);
  // Idle bus with SCL standing high.
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // One SCL pulse; SDA is set mid-low and sampled at the end of high.
  task automatic bit_io(input logic b, output logic r);
    hw(4);
    sda_rel = b;
    hw(4);
    scl = 1'b1;
    hw(8);
    r = sda_line;
    scl = 1'b0;
  endtask
  task automatic bus_start();
    sda_rel = 1'b1;
    scl = 1'b1;
    hw(8);
    sda_rel = 1'b0;
    hw(8);
    scl = 1'b0;
  endtask
  task automatic bus_stop();
    hw(4);
    sda_rel = 1'b0;
    hw(4);
    scl = 1'b1;
    hw(8);
    sda_rel = 1'b1;
    hw(8);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Reads a byte, then acknowledges it unless it is the last.
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule // scr_host_model
`default_nettype wire

// ==== tb/scr_readout_bench.sv ====
`timescale 1ns/1ps
`include "scr_defines.vh"
`default_nettype none
// ==================================================
// Readout bench.
module scr_readout_bench;
  localparam logic [6:0]  PT  = 7'h13; // Arbitrary product type.
  localparam logic [95:0] CAL = 96'hC0DE_1234_5678_9ABC_DEF0_0F1E;
  logic        mclk, rst_b, scl, sda_rel, sda_o, sda_oe, busy;
  logic [23:0] rp, rt;
  logic [15:0] pw [0:7];
  int          n_errors, samples_checked, cyc;
  wire logic   sda_line = sda_rel & ~sda_oe;
  scr_readout #(.PRODUCT_TYPE(PT), .CONV_CYC(21'h000040)) DUT
  (
    .mclk(mclk), .rst_b(rst_b), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe(sda_oe), .raw_pressure_value(rp), .raw_temperature_value(rt),
    .cal_words(CAL), .factory_settings(5'h16), .busy(busy)
  );
  scr_host_model h (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  // Cuts a hang short.
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      n_errors++;
      $display("MISMATCH %0t timeout", $time);
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic send_cmd(input logic [7:0] c);
    logic a, b;
    h.bus_start();
    h.wr_byte({`SCR_I2C_ADDR, 1'b0}, a);
    h.wr_byte(c, b);
    h.bus_stop();
    chk(a && b, "command not acknowledged");
  endtask
  task automatic read_n(input int n, output logic [23:0] v);
    logic a;
    logic [7:0] d;
    v = 24'h000000;
    h.bus_start();
    h.wr_byte({`SCR_I2C_ADDR, 1'b1}, a);
    for (int i = 0; i < n; i++)
    begin
      h.rd_byte(i == n - 1, d);
      v = {v[15:0], d};
    end
    h.bus_stop();
    chk(a, "read address not acknowledged");
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 2500 && busy !== 1'b0; k++)
      h.hw(1);
    chk(busy === 1'b0, "busy stuck");
  endtask
  // Sends the result read command, then collects the three result bytes.
  task automatic read_adc(output logic [23:0] v);
    send_cmd(`SCR_CMD_ADC_READ);
    read_n(3, v);
  endtask
  function automatic logic [3:0] crc4();
    logic [15:0] r, w;
    r = 16'h0000;
    for (int c = 0; c < 16; c++)
    begin
      w = (c < 2) ? pw[0] & 16'h0FFF : (c > 13) ? 16'h0000 : pw[c >> 1];
      r = r ^ ((c % 2 == 1) ? (w & 16'h00FF) : (w >> 8));
      for (int b = 0; b < 8; b++)
        r = r[15] ? (r << 1) ^ 16'h3000 : r << 1;
    end
    return r[15:12];
  endfunction
  task automatic t_none();
    logic [23:0] v;
    read_adc(v);
    chk(v === 24'h000000, "read without conversion");
  endtask
  task automatic t_addr();
    logic a;
    h.bus_start();
    h.wr_byte(8'hEE, a);
    h.bus_stop();
    chk(a === 1'b0, "foreign address acknowledged");
  endtask
  // Every conversion code, each followed by a repeated read.
  task automatic t_conv();
    logic [23:0] v;
    for (int i = 0; i < 12; i++)
    begin
      rp = 24'hC35A01 + i;
      rt = 24'h3CA5F0 - i;
      send_cmd({3'h2, i >= 6, 3'(i % 6), 1'b0});
      chk(busy === 1'b1, "not busy");
      wait_idle();
      read_adc(v);
      chk(v === ((i >= 6) ? rt : rp), "wrong result");
      read_adc(v);
      chk(v === 24'h000000, "repeat read");
    end
  endtask
  task automatic t_busy();
    logic [23:0] v;
    send_cmd(8'h4A);
    read_adc(v);
    chk(v === 24'h000000, "read in conversion");
    chk(busy === 1'b1, "conversion stopped");
    wait_idle();
    read_adc(v);
    chk(v === ~rp, "result not corrupted");
  endtask
  // The reset command clears a finished result before it is read.
  task automatic t_rst();
    logic [23:0] v;
    send_cmd(8'h40);
    wait_idle();
    send_cmd(`SCR_CMD_RESET);
    chk(busy === 1'b0, "busy after reset command");
    read_adc(v);
    chk(v === 24'h000000, "result kept over reset command");
  endtask
  task automatic t_prom();
    logic [23:0] v;
    for (int k = 0; k < 7; k++)
    begin
      send_cmd({4'hA, 3'(k), 1'b0});
      read_n(2, v);
      pw[k] = v[15:0];
    end
    pw[7] = 16'h0000;
    for (int k = 1; k < 7; k++)
      chk(pw[k] === CAL[(k - 1) * 16 +: 16], "calibration word");
    chk(pw[0][11:5] === PT, "product type");
    chk(pw[0][4:0] === 5'h16, "factory settings");
    chk(pw[0][15:12] === crc4(), "crc nibble");
  endtask
  // Reset, then the scenarios.
  initial
  begin
    rst_b = 1'b0;
    rp = 24'h000000;
    rt = 24'h000000;
    repeat (5) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    h.hw(4);
    t_none();
    t_addr();
    t_conv();
    t_busy();
    t_rst();
    t_prom();
    print_verdict();
  end
endmodule // scr_readout_bench
`default_nettype wire
